// File: design/stx_defines.svh
// Purpose: constants for the skip, table read and exclusive-OR executor
// Assumes: 8-bit data memory, 15-bit program words, 12-bit program address
// Notes:   opcode codes are local to this block's decoded command port
`ifndef STX_DEFINES_SVH
`define STX_DEFINES_SVH
`define STX_DATA_W      8
`define STX_ROM_W       15
`define STX_PADDR_W     12
`define STX_RAM_AW      7
`define STX_PAGE_W      4
`define STX_HIGH_W      7
`define STX_LAST_PAGE   4'hF
`define STX_ZERO_BYTE   8'h00
`define STX_SKIP_CYCLES 2
`endif

// File: design/stx_pkg.sv
// Purpose: types for the skip, table read and exclusive-OR executor
// Assumes: stx_defines.svh supplies widths
// Notes:   none
`include "stx_defines.svh"
package stx_pkg;
    typedef enum logic [3:0] {
        STX_OP_NONE,
        STX_OP_SKIP_BYTE,
        STX_OP_COPY_SKIP,
        STX_OP_SKIP_BIT,
        STX_OP_TAB_CUR,
        STX_OP_TAB_LAST,
        STX_OP_XOR_ACC,
        STX_OP_XOR_MEM,
        STX_OP_XOR_IMM
    } stx_op_type;

    typedef enum logic [1:0] {
        STX_ST_IDLE,
        STX_ST_TABLE,
        STX_ST_DUMMY
    } stx_state_type;
endpackage

// File: design/stx_xor_unit.sv
// Purpose: exclusive-OR of two bytes with zero detection
// Assumes: purely combinational
// Notes:   result is registered by the caller
`timescale 1ns/1ps
`include "stx_defines.svh"
module stx_xor_unit (
    input  wire logic [`STX_DATA_W-1:0] a,
    input  wire logic [`STX_DATA_W-1:0] b,
    output logic      [`STX_DATA_W-1:0] y,
    output logic                        zero
);
    always_comb begin
        y    = a ^ b;
        zero = ((a ^ b) == `STX_ZERO_BYTE);
    end
endmodule

// File: design/stx_exec.sv
// Purpose: executes skip, table read and exclusive-OR instructions
// Assumes: operands valid with start; core stalls fetch while busy is high
// Notes:   table read takes a second cycle for the program memory access
`timescale 1ns/1ps
`include "stx_defines.svh"
// Contract
// - Zero byte discards next instruction, two cycles
// - Copy byte to working register, skip if zero
// - Clear selected bit skips with dummy cycle
// - Current-page table read: low to memory, high
// - Register exclusive-OR into working register, zero flag
// - Memory exclusive-OR written back, zero flag only
// - Immediate exclusive-OR into working register, zero flag
module stx_exec (
    input  wire logic                        clk_sys,
    input  wire logic                        nrst,
    input  wire logic                        start,
    input  wire stx_pkg::stx_op_type         op,
    input  wire logic [`STX_RAM_AW-1:0]      mem_addr,
    input  wire logic [`STX_DATA_W-1:0]      mem_rdata,
    input  wire logic [2:0]                  bit_sel,
    input  wire logic [`STX_DATA_W-1:0]      imm_data,
    input  wire logic [`STX_DATA_W-1:0]      table_ptr,
    input  wire logic [`STX_PAGE_W-1:0]      pc_page,
    input  wire logic [`STX_ROM_W-1:0]       rom_rdata,
    output logic                             busy,
    output logic                             discard_next,
    output logic [`STX_PADDR_W-1:0]          rom_addr,
    output logic                             rom_rd,
    output logic                             mem_we,
    output logic [`STX_RAM_AW-1:0]           mem_waddr,
    output logic [`STX_DATA_W-1:0]           mem_wdata,
    output logic [`STX_DATA_W-1:0]           working_register,
    output logic [`STX_HIGH_W-1:0]           table_high_byte,
    output logic                             zero_flag
);
    import stx_pkg::*;

    typedef struct packed {
        stx_state_type               st;
        logic                        discard;
        logic [`STX_PADDR_W-1:0]     raddr;
        logic                        rrd;
        logic                        we;
        logic [`STX_RAM_AW-1:0]      waddr;
        logic [`STX_DATA_W-1:0]      wdata;
        logic [`STX_DATA_W-1:0]      acc;
        logic [`STX_HIGH_W-1:0]      thigh;
        logic                        z;
    } stx_state_struct_type;

    stx_state_struct_type s_q;
    stx_state_struct_type s_d;

    logic [`STX_DATA_W-1:0] xor_b;
    logic [`STX_DATA_W-1:0] xor_y;
    logic                   xor_zero;

    // Per-bit clear detect; the byte test and the bit test share it
    logic [`STX_DATA_W-1:0]  bit_clear;
    logic                    byte_clear;
    logic                    sel_clear;
    logic [`STX_PAGE_W-1:0]  page_sel;
    logic [`STX_PADDR_W-1:0] table_addr;
    logic [`STX_DATA_W-1:0]  table_low;
    logic [`STX_HIGH_W-1:0]  table_high;
    logic                    issue;
    logic                    skip_taken;

    // Every field idles at zero, the state at idle
    localparam stx_state_struct_type reset_state = '{
        st:      STX_ST_IDLE,
        discard: 1'b0,
        raddr:   '0,
        rrd:     1'b0,
        we:      1'b0,
        waddr:   '0,
        wdata:   '0,
        acc:     '0,
        thigh:   '0,
        z:       1'b0
    };

    generate
        for (genvar gi = 0; gi < `STX_DATA_W; gi++) begin : g_clear
            assign bit_clear[gi] = ~mem_rdata[gi];
        end
    endgenerate

    assign byte_clear = &bit_clear;
    assign sel_clear  = bit_clear[bit_sel];

    // Start is only taken in idle; a start during busy is dropped silently
    assign issue = start && (s_q.st == STX_ST_IDLE);

    always_comb begin
        skip_taken = 1'b0;
        // Only the three skip forms may skip
        case (op)
            STX_OP_SKIP_BYTE: skip_taken = byte_clear;
            STX_OP_COPY_SKIP: skip_taken = byte_clear;
            STX_OP_SKIP_BIT:  skip_taken = sel_clear;
            default:          skip_taken = 1'b0;
        endcase
    end

    // Last-page read ignores the current page entirely
    assign page_sel   = (op == STX_OP_TAB_LAST) ? `STX_LAST_PAGE : pc_page;
    assign table_addr = {page_sel, table_ptr};

    // Program word split: low byte to memory, the rest to the high register
    assign table_low  = rom_rdata[`STX_DATA_W-1:0];
    assign table_high = rom_rdata[`STX_ROM_W-1:`STX_DATA_W];

    // Immediate operand replaces the memory byte for the immediate form
    assign xor_b = (op == STX_OP_XOR_IMM) ? imm_data : mem_rdata;

    stx_xor_unit u_xor (
        .a    (s_q.acc),
        .b    (xor_b),
        .y    (xor_y),
        .zero (xor_zero)
    );

    always_comb begin
        s_d         = s_q;
        s_d.discard = 1'b0;
        s_d.rrd     = 1'b0;
        s_d.we      = 1'b0;
        // Strobes default low so each stands one cycle
        case (s_q.st)
            STX_ST_IDLE: begin
                if (issue) begin
                    // Unknown codes fall to default and change nothing
                    case (op)
                        STX_OP_SKIP_BYTE: begin
                            if (skip_taken) begin
                                s_d.discard = 1'b1;
                                s_d.st      = STX_ST_DUMMY;
                            end
                        end
                        STX_OP_COPY_SKIP: begin
                            s_d.acc = mem_rdata;
                            if (skip_taken) begin
                                s_d.discard = 1'b1;
                                s_d.st      = STX_ST_DUMMY;
                            end
                        end
                        STX_OP_SKIP_BIT: begin
                            if (skip_taken) begin
                                s_d.discard = 1'b1;
                                s_d.st      = STX_ST_DUMMY;
                            end
                        end
                        STX_OP_TAB_CUR: begin
                            s_d.raddr = table_addr;
                            s_d.rrd   = 1'b1;
                            s_d.waddr = mem_addr;
                            s_d.st    = STX_ST_TABLE;
                        end
                        STX_OP_TAB_LAST: begin
                            s_d.raddr = table_addr;
                            s_d.rrd   = 1'b1;
                            s_d.waddr = mem_addr;
                            s_d.st    = STX_ST_TABLE;
                        end
                        STX_OP_XOR_ACC, STX_OP_XOR_IMM: begin
                            s_d.acc = xor_y;
                            s_d.z   = xor_zero;
                        end
                        STX_OP_XOR_MEM: begin
                            s_d.we    = 1'b1;
                            s_d.waddr = mem_addr;
                            s_d.wdata = xor_y;
                            s_d.z     = xor_zero;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            STX_ST_TABLE: begin
                // Program word is taken in the cycle the read strobe stands high
                s_d.we    = 1'b1;
                s_d.wdata = table_low;
                s_d.thigh = table_high;
                s_d.st    = STX_ST_IDLE;
            end
            STX_ST_DUMMY: begin
                // Dummy cycle replaces the discarded instruction
                s_d.st = STX_ST_IDLE;
            end
            default: begin
                s_d.st = STX_ST_IDLE;
            end
        endcase
    end

    // Asynchronous clear loads constants only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            s_q <= reset_state;
        end else begin
            s_q <= s_d;
        end
    end


    // Outputs straight from the state register; only busy is decoded from the state after the flops
    assign busy             = (s_q.st != STX_ST_IDLE);
    assign discard_next     = s_q.discard;
    assign rom_addr         = s_q.raddr;
    assign rom_rd           = s_q.rrd;
    assign mem_we           = s_q.we;
    assign mem_waddr        = s_q.waddr;
    assign mem_wdata        = s_q.wdata;
    assign working_register = s_q.acc;
    assign table_high_byte  = s_q.thigh;
    assign zero_flag        = s_q.z;
endmodule

// File: verification/stx_exec_properties.sv
// Purpose: timing relations of the skip, table read and XOR executor
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every stx_exec instance
`timescale 1ns/1ps
module stx_exec_properties
    import stx_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        start,
    input wire stx_op_type  op,
    input wire logic [6:0]  mem_addr,
    input wire logic [7:0]  mem_rdata,
    input wire logic [2:0]  bit_sel,
    input wire logic [7:0]  imm_data,
    input wire logic [7:0]  table_ptr,
    input wire logic [3:0]  pc_page,
    input wire logic [14:0] rom_rdata,
    input wire logic        busy,
    input wire logic        discard_next,
    input wire logic [11:0] rom_addr,
    input wire logic        rom_rd,
    input wire logic        mem_we,
    input wire logic [6:0]  mem_waddr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  working_register,
    input wire logic [6:0]  table_high_byte,
    input wire logic        zero_flag
);
    logic go;
    logic bit_now;
    // Start while busy is ignored, so only idle issues count
    assign go = start && !busy;
    assign bit_now = mem_rdata[bit_sel];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_skip_byte: assert property (go && op == STX_OP_SKIP_BYTE |=> busy == discard_next
        && discard_next == ($past(mem_rdata) == 8'h00) && $stable(zero_flag)) else $error("skip");
    a_copy_skip: assert property (go && op == STX_OP_COPY_SKIP |=>
        working_register == $past(mem_rdata) && discard_next == (working_register == 8'h00))
        else $error("copy skip");
    a_bit_skip: assert property (go && op == STX_OP_SKIP_BIT |=>
        discard_next == !$past(bit_now) && busy == discard_next) else $error("bit skip");
    a_table_cur: assert property (go && op == STX_OP_TAB_CUR |=> rom_rd && busy
        && rom_addr == {$past(pc_page), $past(table_ptr)}
        ##1 mem_we && {table_high_byte, mem_wdata} == $past(rom_rdata)) else $error("tab cur");
    a_table_last: assert property (go && op == STX_OP_TAB_LAST |=> rom_rd
        && rom_addr == {4'hF, $past(table_ptr)} ##1 mem_we && mem_waddr == $past(mem_addr, 2)
        && $stable(zero_flag)) else $error("tab last");
    a_xor_acc: assert property (go && op == STX_OP_XOR_ACC |=>
        working_register == ($past(working_register) ^ $past(mem_rdata))
        && zero_flag == (working_register == 8'h00)) else $error("xor acc");
    a_xor_mem: assert property (go && op == STX_OP_XOR_MEM |=> mem_we
        && mem_wdata == ($past(working_register) ^ $past(mem_rdata))
        && zero_flag == (mem_wdata == 8'h00) && $stable(working_register)) else $error("xor mem");
    a_xor_imm: assert property (go && op == STX_OP_XOR_IMM |=>
        working_register == ($past(working_register) ^ $past(imm_data))
        && zero_flag == (working_register == 8'h00)) else $error("xor imm");
endmodule
bind stx_exec stx_exec_properties u_props (.*);

// File: verification/stx_exec_tb.sv
// Purpose: random self-checking run of the executor
// Assumes: inputs change on the falling edge
// Notes:   start stays high in busy cycles, which must be ignored
`timescale 1ns/1ps
module stx_exec_tb;
    import stx_pkg::*;
    logic        clk_sys, nrst, start, busy, discard_next, rom_rd, mem_we, zero_flag;
    stx_op_type  op;
    logic [2:0]  bit_sel;
    logic [3:0]  pc_page;
    logic [6:0]  mem_addr, mem_waddr, table_high_byte;
    logic [7:0]  mem_rdata, imm_data, table_ptr, mem_wdata, working_register;
    logic [11:0] rom_addr;
    logic [14:0] rom_rdata;
    int          n_fail, n_tests, acc, z, wd, r, i;
    int          seed = 32'h728A09FC;
    stx_exec dut (.*);
    initial begin
        clk_sys = 0;
        forever #50 clk_sys = ~clk_sys;
    end
    initial begin
        #1000000;
        n_fail++;
        summarize;
    end
    task chk(input string n, input logic [14:0] s, input logic [14:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task summarize;
        if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task run(input stx_op_type o);
        logic sk, tb;
        r = $random(seed);
        {imm_data, table_ptr, bit_sel, pc_page, mem_addr} = r[29:0];
        r = $random(seed);
        // Zero operand forced often so skips really happen
        mem_rdata = r[9:8] == 2'h0 ? 8'h00 : r[7:0];
        rom_rdata = r[24:10];
        op = o;
        start = 1;
        tb = o == STX_OP_TAB_CUR || o == STX_OP_TAB_LAST;
        sk = o == STX_OP_SKIP_BIT ? !mem_rdata[bit_sel] : o < STX_OP_SKIP_BIT && mem_rdata == 0;
        wd = (acc ^ mem_rdata) & 255;
        if (o == STX_OP_COPY_SKIP) acc = mem_rdata;
        if (o == STX_OP_XOR_ACC) acc = wd;
        if (o == STX_OP_XOR_IMM) acc = acc ^ imm_data;
        if (o >= STX_OP_XOR_ACC) z = (o == STX_OP_XOR_MEM ? wd : acc) == 0;
        @(negedge clk_sys);
        chk("skip", discard_next, sk);
        chk("busy", busy, sk || tb);
        chk("acc", working_register, acc);
        chk("zero", zero_flag, z);
        chk("we", mem_we, o == STX_OP_XOR_MEM);
        chk("rd", rom_rd, tb);
        if (o == STX_OP_XOR_MEM) chk("wr", {mem_waddr, mem_wdata}, {mem_addr, wd[7:0]});
        if (tb) chk("ra", rom_addr, {o == STX_OP_TAB_LAST ? 4'hF : pc_page, table_ptr});
        if (sk || tb) @(negedge clk_sys);
        if (tb) chk("tab", {table_high_byte, mem_wdata}, rom_rdata);
        if (tb) chk("twe", {mem_we, mem_waddr, zero_flag}, {1'b1, mem_addr, z[0]});
    endtask
    initial begin
        {nrst, start, bit_sel, pc_page, mem_addr, mem_rdata, imm_data, table_ptr, rom_rdata} = '0;
        op = STX_OP_NONE;
        repeat (3) @(negedge clk_sys);
        nrst = 1;
        for (i = 0; i < 400; i++) begin
            r = $random(seed);
            run(stx_op_type'(r[2:0] + 4'h1));
        end
        // Mid-run reset must clear accumulator, flag and busy at once
        nrst = 0;
        #1;
        chk("rst", {busy, working_register, zero_flag}, 15'h0000);
        acc = 0;
        z = 0;
        @(negedge clk_sys);
        nrst = 1;
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            run(stx_op_type'(r[2:0] + 4'h1));
        end
        summarize;
    end
endmodule
